// ===== design/rcp_core.v
// rcp 8-bit cpu core with apb control registers
// Functional notes
// - fetch next word while current instruction executes
// - thirty-two 8-bit working registers, single-cycle access
// - alu reads two registers, writes result, one cycle
// - register pairs form four 16-bit data pointers: r27:r26, r29:r28, r31:r30 and, by wrap, r1:r0
// - the third pointer also reads program memory bytes
// - alu does arithmetic, logic, bit ops, immediate and single-register forms
// - alu results other than mov and ldi update the status flags
// - status register is not saved or restored on interrupts
// - calls and interrupts push return address onto sram stack
// - stack pointer readable and writable in io space
// - boot and application sections each have write and read locks
// - each interrupt has its own vector, gated by global enable
// - lowest vector address pending is served first
// - 64 io addresses, also at data addresses 0x20 to 0x5f
// - single-word instructions except jump and call, which take a second word with a 16-bit target reaching all program space
// - reset pin low longer than minimum pulse resets the core
// - global enable cleared on interrupt entry, set on handler return
// - sign flag is negative xor overflow
// - stack grows down: push decrements, pop increments
`timescale 1ns/1ps
`include "rcp_defines.vh"
module rcp_core #(
   parameter NIRQ = 8
) (
   input  wire            ref_clk,
   input  wire            resetn,
   input  wire            rstPin_n,
   input  wire            psel,
   input  wire            penable,
   input  wire            pwrite,
   input  wire [7:0]      paddr,
   input  wire [31:0]     pwdata,
   output wire [31:0]     prdata,
   output wire            pready,
   output wire            pslverr,
   output wire [15:0]     progAddr,
   input  wire [15:0]     progData,
   output wire            progWrEn,
   output wire [15:0]     progWrAddr,
   output wire [15:0]     progWrData,
   output wire [15:0]     dataAddr,
   output wire [7:0]      dataWrData,
   output wire            dataWrEn,
   output wire            dataRdEn,
   input  wire [7:0]      dataRdData,
   output wire [5:0]      ioAddr,
   output wire [7:0]      ioWrData,
   output wire            ioWrEn,
   output wire            ioRdEn,
   input  wire [7:0]      ioRdData,
   input  wire [NIRQ-1:0] irqReq,
   output wire [NIRQ-1:0] irqAck
);
   localparam [2:0] ST_RUN = 3'd0;
   localparam [2:0] ST_MEM = 3'd1;
   localparam [2:0] ST_PUSH2 = 3'd2;
   localparam [2:0] ST_POP1 = 3'd3;
   localparam [2:0] ST_POP2 = 3'd4;
   localparam [2:0] ST_LPM = 3'd5;
   localparam [31:0] RST_CYC32 = `RCP_RSTPIN_CYC;
   localparam [7:0] RST_CYC = RST_CYC32[7:0];

   reg [7:0]      rf [0:31];
   reg [15:0]     pc_r, savePc_r, sp_r, dAddr_r, pwAddr_r, pwData_r, boot_r;
   reg [15:0]     ir_r;
   reg            irValid_r, memIo_r, lpmHi_r, lpmOk_r, handler_return_instruction_r, ctrl_r;
   reg [2:0]      st_r;
   reg [7:0]      sreg_r, hi_r, retHi_r, dWr_r, ioWr_r;
   reg [4:0]      dst_r;
   reg [5:0]      ioA_r;
   reg            dWrEn_r, dRdEn_r, ioWrEn_r, ioRdEn_r, pwEn_r;
   reg [NIRQ-1:0] ack_r;
   reg [3:0]      lock_r;
   reg [31:0]     prdata_r, rdMux;
   reg            pready_r, pslverr_r, apbHit;
   reg            s1_r, s2_r, s3_r, pinRst_r;
   reg [7:0]      cnt_r;

   assign progAddr = pc_r;
   assign progWrEn = pwEn_r;
   assign progWrAddr = pwAddr_r;
   assign progWrData = pwData_r;
   assign dataAddr = dAddr_r;
   assign dataWrData = dWr_r;
   assign dataWrEn = dWrEn_r;
   assign dataRdEn = dRdEn_r;
   assign ioAddr = ioA_r;
   assign ioWrData = ioWr_r;
   assign ioWrEn = ioWrEn_r;
   assign ioRdEn = ioRdEn_r;
   assign irqAck = ack_r;
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // alu: returns {h, v, c, result}
   function [10:0] aluCalc;
      input [3:0] f;
      input [7:0] a;
      input [7:0] b;
      input       ci;
      reg         sub;
      reg [7:0]   bx;
      reg         cx;
      reg [8:0]   s;
      reg [4:0]   hs;
      reg [7:0]   r;
      reg         h;
      reg         v;
      reg         c;
      begin
         sub = (f == `RCP_ALU_SUB) | (f == `RCP_ALU_SBC) | (f == `RCP_ALU_DEC);
         bx = ((f == `RCP_ALU_INC) | (f == `RCP_ALU_DEC)) ? 8'h01 : b;
         cx = ((f == `RCP_ALU_ADC) | (f == `RCP_ALU_SBC)) & ci;
         if (sub) begin
            bx = ~bx;
            cx = ~cx;
         end
         s = {1'b0, a} + {1'b0, bx} + {8'h00, cx};
         hs = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cx};
         r = s[7:0];
         h = hs[4] ^ sub;
         c = s[8] ^ sub;
         v = (a[7] & bx[7] & ~r[7]) | (~a[7] & ~bx[7] & r[7]);
         case (f)
         `RCP_ALU_AND: begin r = a & b; v = 1'b0; end
         `RCP_ALU_OR: begin r = a | b; v = 1'b0; end
         `RCP_ALU_EOR: begin r = a ^ b; v = 1'b0; end
         `RCP_ALU_MOV: r = b;
         `RCP_ALU_COM: begin r = ~a; c = 1'b1; v = 1'b0; end
         `RCP_ALU_LSR: begin r = {1'b0, a[7:1]}; c = a[0]; v = a[0]; end
         `RCP_ALU_ROR: begin r = {ci, a[7:1]}; c = a[0]; v = ci ^ a[0]; end
         default: ;
         endcase
         aluCalc = {h, v, c, r};
      end
   endfunction

   // lowest pending index wins
   function [7:0] irqFirst;
      input [NIRQ-1:0] q;
      integer          i;
      begin
         irqFirst = 8'h00;
         for (i = NIRQ - 1; i >= 0; i = i - 1)
            if (q[i])
               irqFirst = i[7:0];
      end
   endfunction

   // instruction fields
   wire [3:0]  op = ir_r[15:12];
   wire [4:0]  rdRR = ir_r[9:5];
   wire [4:0]  rdImm = {1'b1, ir_r[11:8]};
   wire [4:0]  rdOne = ir_r[8:4];
   wire [7:0]  imm = ir_r[7:0];
   wire [3:0]  sub = ir_r[3:0];
   wire [15:0] exPc = pc_r - 16'h0001;

   // alu operand select
   reg [3:0] aluF;
   reg [7:0] aluA, aluB;
   reg [4:0] aluD;
   reg       aluUse;
   always @* begin
      aluF = {2'b00, ir_r[11:10]};
      aluA = rf[rdRR];
      aluB = rf[ir_r[4:0]];
      aluD = rdRR;
      aluUse = 1'b1;
      case (op)
      `RCP_OP_ARITH: ;
      `RCP_OP_LOGIC: aluF = {2'b01, ir_r[11:10]};
      `RCP_OP_LDI: begin aluF = `RCP_ALU_MOV; aluB = imm; aluD = rdImm; end
      `RCP_OP_SUBI: begin aluF = `RCP_ALU_SUB; aluA = rf[rdImm]; aluB = imm; aluD = rdImm; end
      `RCP_OP_ANDI: begin aluF = `RCP_ALU_AND; aluA = rf[rdImm]; aluB = imm; aluD = rdImm; end
      `RCP_OP_ORI: begin aluF = `RCP_ALU_OR; aluA = rf[rdImm]; aluB = imm; aluD = rdImm; end
      `RCP_OP_ONE: begin
         aluF = `RCP_ALU_INC + sub;
         aluA = rf[rdOne];
         aluD = rdOne;
         aluUse = sub < `RCP_S_ALUMAX;
      end
      default: aluUse = 1'b0;
      endcase
   end

   wire [10:0] aluOut = aluCalc(aluF, aluA, aluB, sreg_r[`RCP_F_C]);
   wire        fN = aluOut[7];
   wire        fV = aluOut[9];
   wire        keepC = (aluF >= `RCP_ALU_AND) & (aluF <= `RCP_ALU_DEC);
   wire        keepH = aluF >= `RCP_ALU_AND;
   wire [7:0]  sregAlu = {sreg_r[7:6], keepH ? sreg_r[`RCP_F_H] : aluOut[10], fN ^ fV, fV, fN,
                          aluOut[7:0] == 8'h00, keepC ? sreg_r[`RCP_F_C] : aluOut[8]};

   wire [4:0]  ptrLo = `RCP_PTR_X + {2'b00, ir_r[11:10], 1'b0};
   wire [15:0] ptr = {rf[ptrLo | 5'h01], rf[ptrLo]};
   wire [15:0] zp = {rf[31], rf[30]};
   wire [15:0] zw = {1'b0, zp[15:1]};
   wire        isIoOp = op == `RCP_OP_IO;
   wire [15:0] memAddr = isIoOp ? `RCP_IO_BASE + {10'h000, ir_r[5:0]} : ptr;
   wire        memWr = isIoOp ? ir_r[11] : ir_r[9];
   wire [4:0]  memReg = isIoOp ? ir_r[10:6] : rdOne;
   wire        isReg = memAddr <= `RCP_REG_LAST;
   wire        isIo = (memAddr >= `RCP_IO_BASE) & (memAddr <= `RCP_IO_LAST);
   wire [15:0] ioOff16 = memAddr - `RCP_IO_BASE;
   wire [5:0]  ioOff = ioOff16[5:0];
   wire        intHit = (ioOff == `RCP_IO_SPL) | (ioOff == `RCP_IO_SPH) | (ioOff == `RCP_IO_SREG);
   wire [7:0]  intVal = (ioOff == `RCP_IO_SPL) ? sp_r[7:0] :
                        (ioOff == `RCP_IO_SPH) ? sp_r[15:8] : sreg_r;

   wire        execBoot = exPc >= boot_r;
   wire        tgtBoot = zw >= boot_r;
   wire        spmOk = execBoot & ~(tgtBoot ? lock_r[`RCP_L_BOOTW] : lock_r[`RCP_L_APPW]);
   wire        lpmOk = (tgtBoot == execBoot) |
                       ~(tgtBoot ? lock_r[`RCP_L_BOOTR] : lock_r[`RCP_L_APPR]);

   wire [7:0]  irqIdx = irqFirst(irqReq);
   wire        takeIrq = sreg_r[`RCP_F_I] & (|irqReq) & irValid_r & (st_r == ST_RUN);
   wire [15:0] vecAddr = ({8'h00, irqIdx} + 16'h0001) * `RCP_VEC_STEP;
   wire        doCall = takeIrq | (irValid_r & (op == `RCP_OP_CALL));
   wire [15:0] retAddr = takeIrq ? exPc : pc_r + 16'h0001;
   wire        brTake = sreg_r[ir_r[10:8]] == ir_r[11];
   wire        coreRst = ~resetn | pinRst_r;

   always @(posedge ref_clk) begin
      s1_r <= rstPin_n;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (!resetn) begin
         cnt_r <= 8'h00;
         pinRst_r <= 1'b0;
      end else if (!s2_r && !s3_r) begin
         if (cnt_r < RST_CYC)
            cnt_r <= cnt_r + 8'h01;
         else
            pinRst_r <= 1'b1;
      end else if (s2_r && s3_r) begin
         cnt_r <= 8'h00;
         pinRst_r <= 1'b0;
      end
   end

   // core pipeline and execution
   always @(posedge ref_clk) begin
      dWrEn_r <= 1'b0;
      dRdEn_r <= 1'b0;
      ioWrEn_r <= 1'b0;
      ioRdEn_r <= 1'b0;
      pwEn_r <= 1'b0;
      ack_r <= {NIRQ{1'b0}};
      if (coreRst) begin
         pc_r <= `RCP_PC_RST;
         irValid_r <= 1'b0;
         ir_r <= 16'h0000;
         st_r <= ST_RUN;
         sp_r <= `RCP_SP_RST;
         sreg_r <= `RCP_SREG_RST;
         savePc_r <= 16'h0000;
         dAddr_r <= 16'h0000;
         dWr_r <= 8'h00;
         ioA_r <= 6'h00;
         ioWr_r <= 8'h00;
         pwAddr_r <= 16'h0000;
         pwData_r <= 16'h0000;
         {hi_r, retHi_r, dst_r} <= 21'h000000;
         {memIo_r, lpmHi_r, lpmOk_r, handler_return_instruction_r} <= 4'h0;
      end else if (ctrl_r) begin
         case (st_r)
         ST_RUN: begin
            ir_r <= progData;
            irValid_r <= 1'b1;
            pc_r <= pc_r + 16'h0001;
            if (doCall) begin
               dAddr_r <= sp_r;
               dWr_r <= retAddr[7:0];
               dWrEn_r <= 1'b1;
               retHi_r <= retAddr[15:8];
               sp_r <= sp_r - 16'h0001;
               pc_r <= takeIrq ? vecAddr : progData;
               irValid_r <= 1'b0;
               st_r <= ST_PUSH2;
               if (takeIrq) begin
                  sreg_r[`RCP_F_I] <= 1'b0;
                  ack_r <= {{(NIRQ-1){1'b0}}, 1'b1} << irqIdx;
               end
            end else if (irValid_r && aluUse) begin
               rf[aluD] <= aluOut[7:0];
               if (aluF != `RCP_ALU_MOV)
                  sreg_r <= sregAlu;
            end else if (irValid_r) begin
               case (op)
               `RCP_OP_ONE: begin
                  case (sub)
                  `RCP_S_PUSH: begin
                     dAddr_r <= sp_r;
                     dWr_r <= rf[rdOne];
                     dWrEn_r <= 1'b1;
                     sp_r <= sp_r - 16'h0001;
                  end
                  `RCP_S_POP: begin
                     dAddr_r <= sp_r + 16'h0001;
                     sp_r <= sp_r + 16'h0001;
                     dRdEn_r <= 1'b1;
                     dst_r <= rdOne;
                     memIo_r <= 1'b0;
                     st_r <= ST_MEM;
                  end
                  `RCP_S_SEI: sreg_r[`RCP_F_I] <= 1'b1;
                  `RCP_S_CLI: sreg_r[`RCP_F_I] <= 1'b0;
                  `RCP_S_RET, `RCP_S_HANDLER_RETURN_INSTRUCTION: begin
                     dAddr_r <= sp_r + 16'h0001;
                     sp_r <= sp_r + 16'h0001;
                     dRdEn_r <= 1'b1;
                     handler_return_instruction_r <= sub == `RCP_S_HANDLER_RETURN_INSTRUCTION;
                     irValid_r <= 1'b0;
                     st_r <= ST_POP1;
                  end
                  default: ;
                  endcase
               end
               `RCP_OP_BR: begin
                  if (brTake) begin
                     pc_r <= pc_r + {{8{imm[7]}}, imm};
                     irValid_r <= 1'b0;
                  end
               end
               `RCP_OP_JMP: begin
                  pc_r <= progData;
                  irValid_r <= 1'b0;
               end
               `RCP_OP_PTR, `RCP_OP_IO: begin
                  if (isReg) begin
                     if (memWr)
                        rf[memAddr[4:0]] <= rf[memReg];
                     else
                        rf[memReg] <= rf[memAddr[4:0]];
                  end else if (isIo && intHit) begin
                     if (!memWr)
                        rf[memReg] <= intVal;
                     else if (ioOff == `RCP_IO_SPL)
                        sp_r[7:0] <= rf[memReg];
                     else if (ioOff == `RCP_IO_SPH)
                        sp_r[15:8] <= rf[memReg];
                     else
                        sreg_r <= rf[memReg];
                  end else if (isIo) begin
                     ioA_r <= ioOff;
                     ioWr_r <= rf[memReg];
                     ioWrEn_r <= memWr;
                     ioRdEn_r <= ~memWr;
                     memIo_r <= 1'b1;
                     dst_r <= memReg;
                     if (!memWr)
                        st_r <= ST_MEM;
                  end else begin
                     dAddr_r <= memAddr;
                     dWr_r <= rf[memReg];
                     dWrEn_r <= memWr;
                     dRdEn_r <= ~memWr;
                     memIo_r <= 1'b0;
                     dst_r <= memReg;
                     if (!memWr)
                        st_r <= ST_MEM;
                  end
                  if (!isIoOp && ir_r[0])
                     {rf[ptrLo | 5'h01], rf[ptrLo]} <= ptr + 16'h0001;
               end
               `RCP_OP_LPM: begin
                  savePc_r <= pc_r;
                  pc_r <= zw;
                  irValid_r <= 1'b0;
                  dst_r <= rdOne;
                  lpmHi_r <= zp[0];
                  lpmOk_r <= lpmOk;
                  st_r <= ST_LPM;
                  if (ir_r[0])
                     {rf[31], rf[30]} <= zp + 16'h0001;
               end
               `RCP_OP_SPM: begin
                  pwEn_r <= spmOk;
                  pwAddr_r <= zw;
                  pwData_r <= {rf[1], rf[0]};
               end
               default: ;
               endcase
            end
         end
         ST_MEM: begin
            rf[dst_r] <= memIo_r ? ioRdData : dataRdData;
            st_r <= ST_RUN;
         end
         ST_PUSH2: begin
            dAddr_r <= sp_r;
            dWr_r <= retHi_r;
            dWrEn_r <= 1'b1;
            sp_r <= sp_r - 16'h0001;
            st_r <= ST_RUN;
         end
         ST_POP1: begin
            hi_r <= dataRdData;
            dAddr_r <= sp_r + 16'h0001;
            sp_r <= sp_r + 16'h0001;
            dRdEn_r <= 1'b1;
            st_r <= ST_POP2;
         end
         ST_POP2: begin
            pc_r <= {hi_r, dataRdData};
            irValid_r <= 1'b0;
            if (handler_return_instruction_r)
               sreg_r[`RCP_F_I] <= 1'b1;
            st_r <= ST_RUN;
         end
         ST_LPM: begin
            rf[dst_r] <= ~lpmOk_r ? 8'h00 : lpmHi_r ? progData[15:8] : progData[7:0];
            pc_r <= savePc_r;
            st_r <= ST_RUN;
         end
         default: st_r <= ST_RUN;
         endcase
      end
   end

   // apb read decode
   always @* begin
      apbHit = 1'b1;
      case (paddr)
      `RCP_A_CTRL: rdMux = {31'h00000000, ctrl_r};
      `RCP_A_LOCK: rdMux = {28'h0000000, lock_r};
      `RCP_A_BOOT: rdMux = {16'h0000, boot_r};
      `RCP_A_PCSP: rdMux = {sp_r, pc_r};
      `RCP_A_SREG: rdMux = {21'h000000, st_r, sreg_r};
      default: begin rdMux = 32'h00000000; apbHit = 1'b0; end
      endcase
   end

   // apb slave, one access cycle
   always @(posedge ref_clk) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      if (!resetn) begin
         prdata_r <= 32'h00000000;
         ctrl_r <= `RCP_CTRL_RST;
         lock_r <= `RCP_LOCK_RST;
         boot_r <= `RCP_BOOT_RST;
      end else if (psel && !penable) begin
         pready_r <= 1'b1;
         pslverr_r <= ~apbHit;
         prdata_r <= pwrite ? 32'h00000000 : rdMux;
      end else if (psel && penable && pready_r && pwrite) begin
         if (paddr == `RCP_A_CTRL)
            ctrl_r <= pwdata[0];
         if (paddr == `RCP_A_LOCK)
            lock_r <= pwdata[3:0];
         if (paddr == `RCP_A_BOOT)
            boot_r <= pwdata[15:0];
      end
   end
endmodule // rcp_core

// ===== shared/rcp_defines.vh
// constants for the rcp cpu core
`ifndef RCP_DEFINES_VH
`define RCP_DEFINES_VH
// apb register offsets
`define RCP_A_CTRL 8'h00
`define RCP_A_LOCK 8'h04
`define RCP_A_BOOT 8'h08
`define RCP_A_PCSP 8'h0c
`define RCP_A_SREG 8'h10
// reset values
`define RCP_CTRL_RST 1'b1
`define RCP_LOCK_RST 4'h0
`define RCP_BOOT_RST 16'hf000
`define RCP_PC_RST 16'h0000
`define RCP_SP_RST 16'h0000
`define RCP_SREG_RST 8'h00
// lock bit positions
`define RCP_L_APPW 0
`define RCP_L_APPR 1
`define RCP_L_BOOTW 2
`define RCP_L_BOOTR 3
// status flag positions
`define RCP_F_I 7
`define RCP_F_H 5
`define RCP_F_C 0
// data space map
`define RCP_REG_LAST 16'h001f
`define RCP_IO_BASE 16'h0020
`define RCP_IO_LAST 16'h005f
`define RCP_IO_SPL 6'h3a
`define RCP_IO_SPH 6'h3b
`define RCP_IO_SREG 6'h3c
`define RCP_PTR_X 5'h1a
`define RCP_VEC_STEP 16'h0002
// major opcodes
`define RCP_OP_ARITH 4'h1
`define RCP_OP_LOGIC 4'h2
`define RCP_OP_LDI 4'h3
`define RCP_OP_SUBI 4'h4
`define RCP_OP_ANDI 4'h5
`define RCP_OP_ORI 4'h6
`define RCP_OP_ONE 4'h7
`define RCP_OP_BR 4'h8
`define RCP_OP_JMP 4'h9
`define RCP_OP_CALL 4'ha
`define RCP_OP_PTR 4'hb
`define RCP_OP_LPM 4'hc
`define RCP_OP_IO 4'hd
`define RCP_OP_SPM 4'he
// single register sub codes
`define RCP_S_ALUMAX 4'h5
`define RCP_S_PUSH 4'h5
`define RCP_S_POP 4'h6
`define RCP_S_SEI 4'h7
`define RCP_S_CLI 4'h8
`define RCP_S_RET 4'h9
`define RCP_S_HANDLER_RETURN_INSTRUCTION 4'ha
// alu functions
`define RCP_ALU_ADC 4'h1
`define RCP_ALU_SUB 4'h2
`define RCP_ALU_SBC 4'h3
`define RCP_ALU_AND 4'h4
`define RCP_ALU_OR 4'h5
`define RCP_ALU_EOR 4'h6
`define RCP_ALU_MOV 4'h7
`define RCP_ALU_INC 4'h8
`define RCP_ALU_DEC 4'h9
`define RCP_ALU_COM 4'ha
`define RCP_ALU_LSR 4'hb
`define RCP_ALU_ROR 4'hc
// reset pin pulse filter
`define RCP_CLK_MHZ 200
`define RCP_RSTPIN_NS 50
`define RCP_RSTPIN_CYC ((`RCP_RSTPIN_NS*`RCP_CLK_MHZ+999)/1000)
`endif

// ===== bench/rcp_mem_model.sv
// behavioural program flash, data sram and io space beside the core
`timescale 1ns/1ps
module rcp_mem_model (
   input  wire        ref_clk,
   input  wire [15:0] progAddr,
   output wire [15:0] progData,
   input  wire        progWrEn,
   input  wire [15:0] progWrAddr,
   input  wire [15:0] progWrData,
   input  wire [15:0] dataAddr,
   input  wire [7:0]  dataWrData,
   input  wire        dataWrEn,
   input  wire        dataRdEn,
   output wire [7:0]  dataRdData,
   input  wire [5:0]  ioAddr,
   input  wire [7:0]  ioWrData,
   input  wire        ioWrEn,
   input  wire        ioRdEn,
   output wire [7:0]  ioRdData
);
   reg [15:0] rom [0:255];
   reg [7:0]  sram [0:511];
   reg [7:0]  io [0:63];
   reg [7:0]  junk_r = 8'h3c;
   // data and io read data valid while the read strobe stands, junk otherwise; program data always valid
   assign progData   = rom[progAddr[7:0]];
   assign dataRdData = dataRdEn ? sram[dataAddr[8:0]] : junk_r;
   assign ioRdData   = ioRdEn ? io[ioAddr] : ~junk_r;
   // single-cycle write strobes land at the edge
   always @(posedge ref_clk) begin
      junk_r <= junk_r + 8'h5b;
      if (dataWrEn)
         sram[dataAddr[8:0]] <= dataWrData;
      if (ioWrEn)
         io[ioAddr] <= ioWrData;
      if (progWrEn)
         rom[progWrAddr[7:0]] <= progWrData;
   end
endmodule // rcp_mem_model

// ===== bench/rcp_core_assertions.sv
// concurrent checks on the rcp core ports
`timescale 1ns/1ps
module rcp_core_checker #(
   parameter NIRQ = 8
) (
   input wire            ref_clk,
   input wire            resetn,
   input wire            rstPin_n,
   input wire            psel,
   input wire            penable,
   input wire [7:0]      paddr,
   input wire            pready,
   input wire            pslverr,
   input wire [15:0]     progAddr,
   input wire            progWrEn,
   input wire [15:0]     dataAddr,
   input wire            dataWrEn,
   input wire            ioWrEn,
   input wire [NIRQ-1:0] irqReq,
   input wire [NIRQ-1:0] irqAck
);
   reg  [7:0] pinLow_r;
   wire [7:0] pinLow_nxt;
   // cycles with the reset pin held low, saturating
   assign pinLow_nxt = rstPin_n ? 8'h00 : (pinLow_r == 8'hff ? pinLow_r : pinLow_r + 8'h01);
   always @(posedge ref_clk) begin
      pinLow_r <= pinLow_nxt;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   AST_APB_PULSE: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("apb answer not one cycle after setup");
   AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h10 |=> pready && pslverr)
      else $error("unmapped access not refused");
   AST_ERR_READY: assert property (pslverr |-> pready && $past(psel && !penable))
      else $error("error without answer");
   AST_ACK_ONEHOT: assert property (irqAck != 0 |-> $onehot(irqAck))
      else $error("ack not one-hot");
   AST_ACK_LOWEST: assert property (irqAck != 0 |-> (irqAck & $past(irqReq)) == irqAck
      && ((irqAck - 1'b1) & $past(irqReq)) == 0) else $error("ack not lowest request");
   AST_ENTRY_PUSH: assert property (irqAck != 0 |-> ##[0:3] dataWrEn ##1
      (dataWrEn && dataAddr == $past(dataAddr) - 16'h0001)) else $error("no downward push");
   AST_GIE_CLEARED: assert property (irqAck != 0 |=> (irqAck == 0) [*8])
      else $error("interrupt entered again");
   AST_RESET_VECTOR: assert property ($rose(resetn) |-> progAddr == 16'h0000)
      else $error("fetch not from zero");
   AST_PIN_RESET: assert property (pinLow_r >= 8'h12 |-> progAddr == 0 && !dataWrEn && !ioWrEn)
      else $error("pin reset not applied");
   AST_RESET_QUIET: assert property (disable iff (1'b0) !resetn |=> !dataWrEn && !ioWrEn
      && !progWrEn && !pready) else $error("strobe during reset");
   COV_IRQ: cover property (irqAck != 0);
   COV_ERR: cover property (pslverr);
   COV_IO: cover property (ioWrEn);
   COV_PIN: cover property (pinLow_r >= 8'h12);
endmodule // rcp_core_checker
bind rcp_core rcp_core_checker #(.NIRQ(NIRQ)) u_chk (.ref_clk, .resetn, .rstPin_n, .psel,
   .penable, .paddr, .pready, .pslverr, .progAddr, .progWrEn, .dataAddr, .dataWrEn, .ioWrEn,
   .irqReq, .irqAck);

// ===== bench/test_risc_cpu_core_pipeline.sv
// self-checking bench for the rcp cpu core
`timescale 1ns/1ps
module test_risc_cpu_core_pipeline;
   localparam [63:0]  BOOTP = {16'h9000, 16'h0040, 16'h9000, 16'h0060};
   localparam [207:0] MAINP = {16'h3301, 16'h3200, 16'hdcba, 16'hdcfb, 16'h307f, 16'h3101,
      16'h1211, 16'hdc05, 16'ha000, 16'h0050, 16'h7007, 16'h9000, 16'h004b};
   reg         ref_clk = 1'b0;
   reg         resetn = 1'b0;
   reg         rstPin_n = 1'b1;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0;
   reg  [7:0]  irqReq = 8'h00;
   reg  [31:0] rd;
   reg         er;
   wire [31:0] prdata;
   wire        pready, pslverr, progWrEn, dataWrEn, dataRdEn, ioWrEn, ioRdEn;
   wire [15:0] progAddr, progData, progWrAddr, progWrData, dataAddr;
   wire [7:0]  dataWrData, dataRdData, ioWrData, ioRdData, irqAck;
   wire [5:0]  ioAddr;
   integer     failures = 0;
   integer     samplesChecked = 0;
   integer     n;
   rcp_core #(.NIRQ(8)) dut (.ref_clk, .resetn, .rstPin_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .progAddr, .progData, .progWrEn, .progWrAddr,
      .progWrData, .dataAddr, .dataWrData, .dataWrEn, .dataRdEn, .dataRdData, .ioAddr,
      .ioWrData, .ioWrEn, .ioRdEn, .ioRdData, .irqReq, .irqAck);
   rcp_mem_model mem (.ref_clk, .progAddr, .progData, .progWrEn, .progWrAddr, .progWrData,
      .dataAddr, .dataWrData, .dataWrEn, .dataRdEn, .dataRdData, .ioAddr, .ioWrData, .ioWrEn,
      .ioRdEn, .ioRdData);
   // free-running clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   task chk(input string nm, input [31:0] exp, input [31:0] got);
      samplesChecked = samplesChecked + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("unexpected %0s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      integer k;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      for (k = 0; k < 50 && pready !== 1'b1; k = k + 1)
         @(posedge ref_clk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pready", 1, pready);
   endtask
   task waitPc(input [15:0] pc);
      for (n = 0; n < 300 && progAddr !== pc; n = n + 1)
         @(posedge ref_clk);
      chk("pc", pc, progAddr);
   endtask
   task fetchRun;
      waitPc(16'h0041);
      @(posedge ref_clk);
      chk("fetch", 16'h0042, progAddr);
      @(posedge ref_clk);
      chk("fetch", 16'h0043, progAddr);
   endtask
   task aluCallRet;
      for (n = 0; n < 100 && ioWrEn !== 1'b1; n = n + 1)
         @(posedge ref_clk);
      chk("io addr", 6'h05, ioAddr);
      chk("io data", 8'h80, ioWrData);
      waitPc(16'h004c);
      chk("ret lo", 8'h4a, mem.sram[9'h100]);
      chk("ret hi", 8'h00, mem.sram[9'h0ff]);
      apb(1'b0, 8'h0c, 0);
      chk("sp", 16'h0100, rd[31:16]);
      apb(1'b0, 8'h10, 0);
      chk("status", 8'hac, rd[7:0]);
   endtask
   task regAccess;
      apb(1'b0, 8'h00, 0);
      chk("ctrl", 1, rd);
      apb(1'b0, 8'h04, 0);
      chk("locks", 0, rd);
      apb(1'b0, 8'h08, 0);
      chk("boot", 32'hf000, rd);
      apb(1'b1, 8'h04, 32'hf);
      apb(1'b0, 8'h04, 0);
      chk("locks", 32'hf, rd);
      apb(1'b0, 8'h40, 0);
      chk("err", 1, er);
      chk("err data", 0, rd);
   endtask
   task irqPriority;
      irqReq <= 8'h03;
      for (n = 0; n < 100 && irqAck === 8'h00; n = n + 1)
         @(posedge ref_clk);
      chk("ack", 8'h01, irqAck);
      repeat (10) begin
         @(posedge ref_clk);
         chk("ack again", 0, irqAck);
      end
      apb(1'b0, 8'h0c, 0);
      chk("sp", 16'h00fe, rd[31:16]);
      apb(1'b0, 8'h10, 0);
      chk("status", 8'h2c, rd[7:0]);
      irqReq <= 8'h00;
   endtask
   task pinReset;
      rstPin_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk("pc held", 0, progAddr);
      rstPin_n <= 1'b1;
      waitPc(16'h0041);
      apb(1'b0, 8'h04, 0);
      chk("locks kept", 32'hf, rd);
   endtask
   task summarize;
      $display("failures %0d samplesChecked %0d", failures, samplesChecked);
      if (failures == 0 && samplesChecked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // program image: stack pointer loaded before any call, no program store
   initial begin
      for (n = 0; n < 13; n = n + 1) begin
         mem.rom[n + 64] = MAINP[16*(12-n) +: 16];
         if (n < 4)
            mem.rom[n] = BOOTP[16*(3-n) +: 16];
      end
      mem.rom[8'h50] = 16'h7009;
      mem.rom[8'h60] = 16'h9000;
      mem.rom[8'h61] = 16'h0060;
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      fetchRun;
      aluCallRet;
      regAccess;
      irqPriority;
      pinReset;
      summarize;
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge ref_clk);
      failures = failures + 1;
      summarize;
   end
endmodule // test_risc_cpu_core_pipeline
